// ---- cms_pkg.sv ----
// Purpose: Shared constants and types for the control mode strap decode
// Assumes: Strap pins that can sit at mid-supply arrive as a two-bit level code
// Notes:   Host registers are 32-bit words on APB
package cms_pkg;
	typedef enum logic [1:0] {
		CMS_LVL_LOW  = 2'h0,
		CMS_LVL_MID  = 2'h1,
		CMS_LVL_HIGH = 2'h2
	} cms_level_t;

	typedef enum logic [1:0] {
		CMS_MODE_HW       = 2'h0,
		CMS_MODE_SERIAL   = 2'h1,
		CMS_MODE_PARALLEL = 2'h3
	} cms_mode_t;

	// Bit 1 multiplexed bus, bit 0 Intel style
	typedef enum logic [1:0] {
		CMS_PV_SEP_MOT   = 2'h0,
		CMS_PV_SEP_INTEL = 2'h1,
		CMS_PV_MUX_MOT   = 2'h2,
		CMS_PV_MUX_INTEL = 2'h3
	} cms_pvar_t;

	typedef enum logic [1:0] {
		CMS_JIT_TX  = 2'h0,
		CMS_JIT_OFF = 2'h1,
		CMS_JIT_RX  = 2'h3
	} cms_jit_t;

	typedef enum logic [2:0] {
		CMS_H_IDLE  = 3'h0,
		CMS_H_CSLOW = 3'h1,
		CMS_H_SHIFT = 3'h3,
		CMS_H_HOLD  = 3'h2,
		CMS_H_GAP   = 3'h6
	} cms_hstate_t;

	localparam int        CMS_WORD_BITS     = 16;
	localparam int        CMS_SCLK_HALF_CYC = 8;
	localparam int        CMS_CS_GAP_CYC    = 8;
	localparam logic [7:0] CMS_OFS_CTRL     = 8'h00;
	localparam logic [7:0] CMS_OFS_TXDATA   = 8'h04;
	localparam logic [7:0] CMS_OFS_STATUS   = 8'h08;
	localparam int        CMS_CTRL_TOP_LSB  = 0;
	localparam int        CMS_CTRL_MUX_BIT  = 2;
	localparam int        CMS_CTRL_INTEL_BIT = 3;
	localparam int        CMS_CTRL_AMI_BIT  = 4;
	localparam int        CMS_CTRL_JIT_LSB  = 5;
	localparam int        CMS_CTRL_W        = 7;
	localparam logic [6:0] CMS_CTRL_RST     = 7'h21;
	localparam int        CMS_STAT_BUSY_BIT = 0;
	localparam int        CMS_STAT_INT_BIT  = 1;
	localparam int        CMS_STAT_RX_LSB   = 16;
endpackage

// ---- cms_link_if.sv ----
// Purpose: Strap and host pins between the line interface and its host
// Assumes: Tri-level pins carried as cms_level_t codes
// Notes:   Serial data out floats high when the device does not drive it
`timescale 1ns/1ps
interface cms_link_if;
	import cms_pkg::*;
	logic [1:0] ctrlSelTop;
	logic       busMuxSel;
	logic       hostStyleSel;
	logic       lineCodeSel;
	logic [1:0] csJitterSel;
	logic       sclk;
	logic       serialHostIn;
	logic       serialHostOut;
	logic       serialHostOutEn;
	logic       serialHostWire;
	logic       intN;

	// Pull-up when the device releases the line
	assign serialHostWire = serialHostOutEn ? serialHostOut : 1'b1;

	modport device (
		input  ctrlSelTop,
		input  busMuxSel,
		input  hostStyleSel,
		input  lineCodeSel,
		input  csJitterSel,
		input  sclk,
		input  serialHostIn,
		output serialHostOut,
		output serialHostOutEn,
		output intN
	);
	modport host (
		output ctrlSelTop,
		output busMuxSel,
		output hostStyleSel,
		output lineCodeSel,
		output csJitterSel,
		output sclk,
		output serialHostIn,
		input  serialHostWire,
		input  intN
	);
endinterface

// ---- cms_device_end.sv ----
// Purpose: Control mode decode and chip-select gated serial port of the device
// Assumes: All pins come from outside and pass two flip-flops first
// Notes:   Parallel bus cycles and line coding themselves live elsewhere
//
// Overview of operation
// - Top select low gives hardware strap mode
// - Two selects pick the parallel bus variant
// - Mux select low separate, high multiplexed
// - Board grounds mux select outside parallel
// - Style select low Motorola, high Intel
// - Hardware mode: code low B8ZS/HDB3, high AMI
// - Board grounds line code in serial
// - Serial uses cs, clock, in, out, interrupt
// - Chip select low enables; high ignores activity
// - Fresh chip select fall per access
// - Chip select held low until access ends
// - Hardware mode: jitter tx, bypass, rx
`timescale 1ns/1ps
module cms_device_end #(
	parameter int WORD_BITS = cms_pkg::CMS_WORD_BITS
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	// Pins toward the host
	cms_link_if.device                link,
	// Decoded configuration
	output cms_pkg::cms_mode_t        ctrlMode,
	output cms_pkg::cms_pvar_t        parallelVariant,
	output logic                      busMuxed,
	output logic                      hostIntel,
	output logic                      lineCodeAmi,
	output cms_pkg::cms_jit_t         jitterPath,
	// Host access events
	input  wire logic                 irqReq,
	output logic                      hostEnable,
	output logic                      accessStart,
	output logic                      rxValid,
	output logic [WORD_BITS-1:0]      rxWord,
	output logic                      frameError
);
	import cms_pkg::*;

	localparam int PIN_W = 9;
	localparam int CNT_W = $clog2(WORD_BITS + 1);

	logic [PIN_W-1:0]     pinRaw;
	logic [PIN_W-1:0]     pinMeta_r;
	logic [PIN_W-1:0]     pinSync_r;
	logic                 sclkPrev_r;
	logic                 csLowPrev_r;
	logic [CNT_W-1:0]     bitCnt_r;
	logic [WORD_BITS-1:0] rxShift_r;
	logic [WORD_BITS-1:0] txShift_r;
	cms_mode_t            ctrlMode_r;
	cms_pvar_t            pvar_r;
	cms_jit_t             jitter_r;
	logic                 busMuxed_r;
	logic                 hostIntel_r;
	logic                 lineCodeAmi_r;
	logic                 hostEnable_r;
	logic                 accessStart_r;
	logic                 rxValid_r;
	logic [WORD_BITS-1:0] rxWord_r;
	logic                 frameError_r;
	logic                 dataOut_r;
	logic                 dataOutEn_r;
	logic                 intN_r;

	assign pinRaw = {link.ctrlSelTop, link.busMuxSel, link.hostStyleSel,
		link.lineCodeSel, link.csJitterSel, link.sclk, link.serialHostIn};

	// Synchronised pin fields
	wire [1:0] topLvl    = pinSync_r[8:7];
	wire       muxPin    = pinSync_r[6];
	wire       stylePin  = pinSync_r[5];
	wire       codePin   = pinSync_r[4];
	wire [1:0] csJitLvl  = pinSync_r[3:2];
	wire       sclkS     = pinSync_r[1];
	wire       dataInS   = pinSync_r[0];

	// Mode decode
	wire cms_mode_t modeNxt = (topLvl == CMS_LVL_LOW)  ? CMS_MODE_HW :
		(topLvl == CMS_LVL_HIGH) ? CMS_MODE_PARALLEL : CMS_MODE_SERIAL;
	wire hwMode     = (modeNxt == CMS_MODE_HW);
	wire serialMode = (modeNxt == CMS_MODE_SERIAL);
	wire parMode    = (modeNxt == CMS_MODE_PARALLEL);
	wire hostMode   = ~hwMode;

	// Parallel variant from the two low selects
	wire       busMuxedNxt  = parMode & muxPin;
	wire       hostIntelNxt = parMode & stylePin;
	wire cms_pvar_t pvarNxt = cms_pvar_t'({busMuxedNxt, hostIntelNxt});

	// Strap-only selections
	wire lineCodeAmiNxt = hwMode & codePin;
	wire cms_jit_t jitterNxt = !hwMode ? CMS_JIT_OFF :
		(csJitLvl == CMS_LVL_LOW)  ? CMS_JIT_TX :
		(csJitLvl == CMS_LVL_HIGH) ? CMS_JIT_RX : CMS_JIT_OFF;

	// Chip select shares its pin with the jitter select
	wire csLow     = hostMode & (csJitLvl == CMS_LVL_LOW);
	wire csFall    = csLow & ~csLowPrev_r;
	wire csRise    = ~csLow & csLowPrev_r;
	wire serActive = serialMode & csLow;
	wire sclkRise  = sclkS & ~sclkPrev_r;
	wire sclkFall  = ~sclkS & sclkPrev_r;
	wire bitsFull  = (bitCnt_r == CNT_W'(WORD_BITS));
	wire takeBit   = serActive & sclkRise & ~bitsFull;
	wire shiftOut  = serActive & sclkFall;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
		end else begin
			pinMeta_r <= pinRaw;
			pinSync_r <= pinMeta_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrlMode_r    <= CMS_MODE_HW;
			pvar_r        <= CMS_PV_SEP_MOT;
			busMuxed_r    <= 1'b0;
			hostIntel_r   <= 1'b0;
			lineCodeAmi_r <= 1'b0;
			jitter_r      <= CMS_JIT_OFF;
		end else begin
			ctrlMode_r    <= modeNxt;
			pvar_r        <= pvarNxt;
			busMuxed_r    <= busMuxedNxt;
			hostIntel_r   <= hostIntelNxt;
			lineCodeAmi_r <= lineCodeAmiNxt;
			jitter_r      <= jitterNxt;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sclkPrev_r    <= 1'b0;
			csLowPrev_r   <= 1'b0;
			hostEnable_r  <= 1'b0;
			accessStart_r <= 1'b0;
		end else begin
			sclkPrev_r    <= sclkS;
			csLowPrev_r   <= csLow;
			hostEnable_r  <= csLow;
			accessStart_r <= csFall;
		end
	end

	// Receive shifter, counted per access
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bitCnt_r  <= '0;
			rxShift_r <= '0;
		end else if (csFall) begin
			bitCnt_r  <= '0;
		end else if (takeBit) begin
			rxShift_r <= {rxShift_r[WORD_BITS-2:0], dataInS};
			bitCnt_r  <= bitCnt_r + CNT_W'(1);
		end
	end

	// Word completes only when chip select returns high
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rxValid_r    <= 1'b0;
			rxWord_r     <= '0;
			frameError_r <= 1'b0;
		end else begin
			rxValid_r    <= csRise & bitsFull;
			frameError_r <= csRise & ~bitsFull;
			if (csRise && bitsFull) begin
				rxWord_r <= rxShift_r;
			end
		end
	end

	// Echo of the last word, MSB first, shifted on falling serial clock
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			txShift_r   <= '0;
			dataOut_r   <= 1'b1;
			dataOutEn_r <= 1'b0;
			intN_r      <= 1'b1;
		end else begin
			if (csFall) begin
				txShift_r <= rxWord_r;
			end else if (shiftOut) begin
				txShift_r <= {txShift_r[WORD_BITS-2:0], 1'b0};
			end
			dataOut_r   <= txShift_r[WORD_BITS-1];
			dataOutEn_r <= serActive;
			intN_r      <= ~(irqReq & hostMode);
		end
	end

	assign ctrlMode             = ctrlMode_r;
	assign parallelVariant      = pvar_r;
	assign busMuxed             = busMuxed_r;
	assign hostIntel            = hostIntel_r;
	assign lineCodeAmi          = lineCodeAmi_r;
	assign jitterPath           = jitter_r;
	assign hostEnable           = hostEnable_r;
	assign accessStart          = accessStart_r;
	assign rxValid              = rxValid_r;
	assign rxWord               = rxWord_r;
	assign frameError           = frameError_r;
	assign link.serialHostOut   = dataOut_r;
	assign link.serialHostOutEn = dataOutEn_r;
	assign link.intN            = intN_r;
endmodule

// ---- cms_host_end.sv ----
// Purpose: Host side: drives the straps and runs serial accesses under APB
// Assumes: APB master on sys_clk; device returns pins through two flip-flops
// Notes:   One chip select low period per started access
`timescale 1ns/1ps
module cms_host_end #(
	parameter int WORD_BITS = cms_pkg::CMS_WORD_BITS,
	parameter int HALF_CYC  = cms_pkg::CMS_SCLK_HALF_CYC,
	parameter int GAP_CYC   = cms_pkg::CMS_CS_GAP_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins toward the device
	cms_link_if.host         link
);
	import cms_pkg::*;

	localparam int CNT_W = $clog2(WORD_BITS + 1);
	localparam int DIV_W = 8;

	cms_hstate_t               state_r;
	logic [CMS_CTRL_W-1:0]     ctrl_r;
	logic [DIV_W-1:0]          divCnt_r;
	logic [CNT_W-1:0]          bitCnt_r;
	logic [WORD_BITS-1:0]      txShift_r;
	logic [WORD_BITS-1:0]      rxShift_r;
	logic [WORD_BITS-1:0]      rxWord_r;
	logic [1:0]                inMeta_r;
	logic [1:0]                inSync_r;
	logic                      sclk_r;
	logic [1:0]                topPin_r;
	logic                      muxPin_r;
	logic                      stylePin_r;
	logic                      codePin_r;
	logic [1:0]                csJit_r;
	logic                      pready_r;
	logic                      pslverr_r;
	logic [31:0]               prdata_r;

	wire [1:0] topReq    = ctrl_r[CMS_CTRL_TOP_LSB +: 2];
	wire       hwReq     = (topReq == CMS_LVL_LOW);
	wire       serialReq = (topReq == CMS_LVL_MID);
	wire       parReq    = (topReq == CMS_LVL_HIGH);
	wire       busy      = (state_r != CMS_H_IDLE);
	wire       inAccess  = busy & (state_r != CMS_H_GAP);

	// APB decode
	wire take     = psel & penable & ~pready_r;
	// Writes land on the edge that completes the transfer
	wire done     = psel & penable & pready_r;
	wire hitCtrl  = (paddr == CMS_OFS_CTRL);
	wire hitTx    = (paddr == CMS_OFS_TXDATA);
	wire hitStat  = (paddr == CMS_OFS_STATUS);
	wire mapped   = hitCtrl | hitTx | hitStat;
	wire start    = done & pwrite & hitTx & ~busy & serialReq;
	wire [31:0] rdNxt = hitCtrl ? {25'h0, ctrl_r} :
		hitStat ? {rxWord_r, 14'h0, ~inSync_r[1], busy} : 32'h0;

	wire halfTick = (divCnt_r == DIV_W'(HALF_CYC - 1));
	wire gapTick  = (divCnt_r == DIV_W'(GAP_CYC - 1));
	wire lastBit  = (bitCnt_r == CNT_W'(WORD_BITS - 1));

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
			ctrl_r    <= CMS_CTRL_RST;
		end else begin
			pready_r <= take;
			if (take) begin
				pslverr_r <= ~mapped;
				prdata_r  <= pwrite ? 32'h0 : rdNxt;
			end
			if (done && pwrite && hitCtrl && !busy) begin
				ctrl_r <= pwdata[CMS_CTRL_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			inMeta_r <= 2'h3;
			inSync_r <= 2'h3;
		end else begin
			inMeta_r <= {link.intN, link.serialHostWire};
			inSync_r <= inMeta_r;
		end
	end

	// Access sequencer
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r   <= CMS_H_IDLE;
			divCnt_r  <= '0;
			bitCnt_r  <= '0;
			sclk_r    <= 1'b0;
			txShift_r <= '0;
			rxShift_r <= '0;
			rxWord_r  <= '0;
		end else begin
			divCnt_r <= halfTick ? '0 : divCnt_r + DIV_W'(1);
			case (state_r)
				CMS_H_IDLE: begin
					divCnt_r <= '0;
					if (start) begin
						state_r   <= CMS_H_CSLOW;
						txShift_r <= pwdata[WORD_BITS-1:0];
						bitCnt_r  <= '0;
					end
				end
				CMS_H_CSLOW: begin
					if (halfTick) begin
						state_r <= CMS_H_SHIFT;
					end
				end
				CMS_H_SHIFT: begin
					if (halfTick && !sclk_r) begin
						sclk_r    <= 1'b1;
						rxShift_r <= {rxShift_r[WORD_BITS-2:0], inSync_r[0]};
					end else if (halfTick) begin
						sclk_r    <= 1'b0;
						txShift_r <= {txShift_r[WORD_BITS-2:0], 1'b0};
						bitCnt_r  <= bitCnt_r + CNT_W'(1);
						if (lastBit) begin
							state_r <= CMS_H_HOLD;
						end
					end
				end
				CMS_H_HOLD: begin
					if (halfTick) begin
						state_r  <= CMS_H_GAP;
						rxWord_r <= rxShift_r;
					end
				end
				CMS_H_GAP: begin
					if (gapTick) begin
						state_r <= CMS_H_IDLE;
					end
				end
				default: begin
					state_r <= CMS_H_IDLE;
				end
			endcase
		end
	end

	// Strap and chip select pins
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			topPin_r   <= CMS_LVL_MID;
			muxPin_r   <= 1'b0;
			stylePin_r <= 1'b0;
			codePin_r  <= 1'b0;
			csJit_r    <= CMS_LVL_HIGH;
		end else begin
			topPin_r   <= topReq;
			muxPin_r   <= parReq & ctrl_r[CMS_CTRL_MUX_BIT];
			stylePin_r <= parReq & ctrl_r[CMS_CTRL_INTEL_BIT];
			codePin_r  <= hwReq & ctrl_r[CMS_CTRL_AMI_BIT];
			if (hwReq) begin
				csJit_r <= ctrl_r[CMS_CTRL_JIT_LSB +: 2];
			end else begin
				csJit_r <= inAccess ? CMS_LVL_LOW : CMS_LVL_HIGH;
			end
		end
	end

	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign link.ctrlSelTop   = topPin_r;
	assign link.busMuxSel    = muxPin_r;
	assign link.hostStyleSel = stylePin_r;
	assign link.lineCodeSel  = codePin_r;
	assign link.csJitterSel  = csJit_r;
	assign link.sclk         = sclk_r;
	assign link.serialHostIn = txShift_r[WORD_BITS-1];
endmodule

// ---- cms_link_asserts.sv ----
// Purpose: Concurrent checks on the strap and serial pins between both ends
// Assumes: Default serial half period and gap of 8 cycles
// Notes:   Chip select counts only while the top select sits at mid level
`timescale 1ns/1ps
module cms_link_asserts
	import cms_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rstn,
	// Link pins
	input wire logic [1:0] ctrlSelTop,
	input wire logic       busMuxSel,
	input wire logic       lineCodeSel,
	input wire logic [1:0] csJitterSel,
	input wire logic       sclk,
	input wire logic       serialHostOutEn
);
	wire csLow;

	assign csLow = (csJitterSel == CMS_LVL_LOW) && (ctrlSelTop == CMS_LVL_MID);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	property p_mux_ground; ctrlSelTop != CMS_LVL_HIGH |-> !busMuxSel; endproperty
	a_mux_ground: assert property (p_mux_ground) else $error("mux select not grounded");
	property p_code_ground; ctrlSelTop == CMS_LVL_MID |-> !lineCodeSel; endproperty
	a_code_ground: assert property (p_code_ground) else $error("line code not grounded");
	property p_sclk_framed; sclk |-> csLow; endproperty
	a_sclk_framed: assert property (p_sclk_framed) else $error("clock outside select");
	property p_cs_lead; $rose(csLow) |-> !sclk [*8]; endproperty
	a_cs_lead: assert property (p_cs_lead) else $error("clock too soon after select");
	property p_frame_len; $rose(csLow) |-> ##[262:282] $fell(csLow); endproperty
	a_frame_len: assert property (p_frame_len) else $error("select low time wrong");
	property p_gap; $fell(csLow) |-> !csLow [*8]; endproperty
	a_gap: assert property (p_gap) else $error("select gap too short");
	property p_sclk_high; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
	a_sclk_high: assert property (p_sclk_high) else $error("clock high time wrong");
	property p_oe_framed; $rose(serialHostOutEn) |-> csLow; endproperty
	a_oe_framed: assert property (p_oe_framed) else $error("drive without select");
	property p_oe_release; !csLow [*6] |-> !serialHostOutEn; endproperty
	a_oe_release: assert property (p_oe_release) else $error("drive after release");

	c_frame: cover property ($rose(csLow));
	c_oe: cover property ($rose(serialHostOutEn));
	c_hw_tx: cover property (ctrlSelTop == CMS_LVL_LOW && csJitterSel == CMS_LVL_LOW);
endmodule

// ---- tb.sv ----
// Purpose: Drives the host end over APB and checks both ends of the link
// Assumes: Default serial timing parameters
// Notes:   Device serial output echoes the previous word
`timescale 1ns/1ps
module tb;
	import cms_pkg::*;
	logic        sys_clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irqReq;
	cms_mode_t   ctrlMode;
	cms_pvar_t   parallelVariant;
	logic        busMuxed;
	logic        hostIntel;
	logic        lineCodeAmi;
	cms_jit_t    jitterPath;
	logic        hostEnable;
	logic        accessStart;
	logic        rxValid;
	logic        frameError;
	logic [15:0] rxWord;
	logic [31:0] q;
	logic        e;
	logic [15:0] prev;
	logic [15:0] words [3] = '{16'hA5C3, 16'h8001, 16'h7FFE};
	logic [6:0]  modes [9] = '{7'h22, 7'h2A, 7'h26, 7'h2E, 7'h00, 7'h30, 7'h40, 7'h4C, 7'h35};
	int          error_cnt = 0;
	int          total_checks = 0;
	int          startCnt = 0;
	int          rxCnt = 0;
	int          errCnt = 0;
	int          enCnt = 0;

	cms_link_if link ();
	cms_device_end u_cms_device_end (.sys_clk, .rstn, .link(link), .ctrlMode, .parallelVariant,
		.busMuxed, .hostIntel, .lineCodeAmi, .jitterPath, .irqReq, .hostEnable, .accessStart,
		.rxValid, .rxWord, .frameError);
	cms_host_end u_cms_host_end (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .link(link));
	cms_link_asserts u_cms_link_asserts (.sys_clk, .rstn, .ctrlSelTop(link.ctrlSelTop),
		.busMuxSel(link.busMuxSel), .lineCodeSel(link.lineCodeSel),
		.csJitterSel(link.csJitterSel), .sclk(link.sclk),
		.serialHostOutEn(link.serialHostOutEn));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Pulse and enable monitors
	always @(posedge sys_clk) begin
		if (accessStart === 1'b1) startCnt++;
		if (rxValid === 1'b1) rxCnt++;
		if (frameError === 1'b1) errCnt++;
		if (hostEnable === 1'b1) enCnt++;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready wait", n, 32'h2);
		@(posedge sys_clk);
	endtask

	task automatic waitIdle();
		int n = 0;
		do begin
			apb(1'b0, CMS_OFS_STATUS, 32'h0);
			n++;
		end while (q[CMS_STAT_BUSY_BIT] !== 1'b0 && n < 200);
		if (n >= 200) begin
			chk("busy", q, 32'h0);
			results();
		end
	endtask

	task automatic modeCase(input logic [6:0] c);
		logic      hw;
		logic      par;
		cms_mode_t md;
		cms_jit_t  jp;
		hw = (c[1:0] == 2'h0);
		par = (c[1:0] == 2'h2);
		md = hw ? CMS_MODE_HW : par ? CMS_MODE_PARALLEL : CMS_MODE_SERIAL;
		jp = !hw ? CMS_JIT_OFF : (c[6:5] == 2'h0) ? CMS_JIT_TX :
			(c[6:5] == 2'h2) ? CMS_JIT_RX : CMS_JIT_OFF;
		apb(1'b1, CMS_OFS_CTRL, {25'h0, c});
		if (hw || par) apb(1'b1, CMS_OFS_TXDATA, 32'h5555);
		repeat (6) @(posedge sys_clk);
		chk("config", 32'({ctrlMode, parallelVariant, busMuxed, hostIntel, lineCodeAmi, jitterPath}),
			32'({md, par & c[2], par & c[3], par & c[2], par & c[3], hw & c[4], jp}));
		chk("straps", 32'({link.busMuxSel, link.hostStyleSel, link.lineCodeSel}),
			32'({par & c[2], par & c[3], hw & c[4]}));
		chk("enable", 32'(hostEnable), 32'h0);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		$display("watchdog expired");
		results();
	end

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		irqReq = 1'b0;
		prev = 16'h0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, CMS_OFS_CTRL, 32'h0);
		chk("ctrl reset", q, 32'h21);
		chk("ctrl err", 32'(e), 32'h0);
		apb(1'b1, CMS_OFS_STATUS, 32'hFFFFFFFF);
		apb(1'b0, CMS_OFS_STATUS, 32'h0);
		chk("status", q, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped", {q[30:0], e}, 32'h1);
		$display("test registers done");
		foreach (words[i]) begin
			apb(1'b1, CMS_OFS_TXDATA, {16'h0, words[i]});
			waitIdle();
			chk("rx word", {16'h0, rxWord}, {16'h0, words[i]});
			chk("echo", q, {prev, 16'h0});
			prev = words[i];
		end
		apb(1'b1, CMS_OFS_TXDATA, 32'h1234);
		apb(1'b1, CMS_OFS_TXDATA, 32'hFFFF);
		waitIdle();
		chk("busy refuse", {16'h0, rxWord}, 32'h1234);
		chk("starts", startCnt, 4);
		chk("frames", rxCnt, 4);
		chk("short", errCnt, 0);
		chk("enabled", 32'(enCnt > 0), 32'h1);
		$display("test serial done");
		irqReq <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("irq pin", 32'(link.intN), 32'h0);
		apb(1'b0, CMS_OFS_STATUS, 32'h0);
		chk("irq flag", 32'(q[CMS_STAT_INT_BIT]), 32'h1);
		irqReq <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("irq idle", 32'(link.intN), 32'h1);
		$display("test interrupt done");
		foreach (modes[i]) modeCase(modes[i]);
		chk("no start", startCnt, 4);
		$display("test modes done");
		results();
	end
endmodule
